//--- core/gate_select_pkg.sv
// Constants for the logic cell gate term select stage.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package gate_select_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int GATE_N     = 4;
  localparam int DATA_N     = 4;
  localparam int TERM_W     = 8;
  localparam int SRC_SEL_W  = 5;
  localparam int SRC_N      = 32;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] GATE1_TERM_SELECT_OFS = 8'h00;
  localparam logic [7:0] GATE2_TERM_SELECT_OFS = 8'h04;
  localparam logic [7:0] GATE3_TERM_SELECT_OFS = 8'h08;
  localparam logic [7:0] GATE4_TERM_SELECT_OFS = 8'h0C;
  localparam logic [7:0] DATA1_SOURCE_OFS      = 8'h10;
  localparam logic [7:0] DATA2_SOURCE_OFS      = 8'h14;
  localparam logic [7:0] DATA3_SOURCE_OFS      = 8'h18;
  localparam logic [7:0] DATA4_SOURCE_OFS      = 8'h1C;
  localparam logic [7:0] GATE_INVERT_OFS       = 8'h20;
  localparam logic [7:0] GATE_STATUS_OFS       = 8'h24;

  // ---------------------------------------------------------------
  // Register index codes from the address decoder
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_GATE_BASE = 4'h0;
  localparam logic [3:0] IDX_DATA_BASE = 4'h4;
  localparam logic [3:0] IDX_INVERT    = 4'h8;
  localparam logic [3:0] IDX_STATUS    = 4'h9;
  localparam logic [3:0] IDX_NONE      = 4'hF;

  // ---------------------------------------------------------------
  // Term select field positions, same for every gate
  // ---------------------------------------------------------------
  localparam int TERM_D4_TRUE = 7;
  localparam int TERM_D4_INV  = 6;
  localparam int TERM_D3_TRUE = 5;
  localparam int TERM_D3_INV  = 4;
  localparam int TERM_D2_TRUE = 3;
  localparam int TERM_D2_INV  = 2;
  localparam int TERM_D1_TRUE = 1;
  localparam int TERM_D1_INV  = 0;

  // Status fields: raw gates low nibble, inverted-applied high nibble
  localparam int STATUS_RAW_LSB = 0;
  localparam int STATUS_OUT_LSB = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] TERM_SELECT_RESET = 8'h00;
  localparam logic [4:0] SOURCE_SEL_RESET  = 5'h00;
  localparam logic [3:0] INVERT_RESET      = 4'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- core/gate_term_or.sv
// One gate of the input gating stage: OR of selected true/inverted terms.
// Assumes the data inputs are already in the core clock domain.
`timescale 1ns/1ns
module gate_term_or (
  input  wire logic [3:0] data_in,
  input  wire logic [7:0] term_sel,
  input  wire logic       invert,
  output logic            raw_out,
  output logic            gate_out
);

  // ---------------------------------------------------------------
  // Term expansion
  // ---------------------------------------------------------------
  // Odd bits carry the true form, even bits the inverted form
  logic [7:0] terms;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_term
      assign terms[2*i+1] = data_in[i];
      assign terms[2*i]   = ~data_in[i];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Combine and polarity
  // ---------------------------------------------------------------
  // No enabled term gives zero before the polarity stage
  assign raw_out  = |(terms & term_sel);
  assign gate_out = raw_out ^ invert;

endmodule

//--- core/gate_select_top.sv
// Logic cell input gating stage with its AXI4-Lite register file.
// Assumes SOURCE_IN comes from pins or other domains; all else is on CLOCK.
//
// Operation
// - Gate 1 terms chosen by its select register
// - Gate 2 terms chosen by its select register
// - Gate 3 terms chosen by its select register
// - Gate 4 terms chosen by its select register
// - Select bits read/write, kept across warm reset
// - Each data input picks one of 32 sources
// - Per-gate invert bit flips gate output
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module gate_select_top (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        WARM_RESET,
  input  wire logic [31:0] SOURCE_IN,
  output logic      [3:0]  GATE_OUT,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    logic [3:0] idx;
    idx = gate_select_pkg::IDX_NONE;
    case ({addr[7:2], 2'h0})
      gate_select_pkg::GATE1_TERM_SELECT_OFS: idx = 4'h0;
      gate_select_pkg::GATE2_TERM_SELECT_OFS: idx = 4'h1;
      gate_select_pkg::GATE3_TERM_SELECT_OFS: idx = 4'h2;
      gate_select_pkg::GATE4_TERM_SELECT_OFS: idx = 4'h3;
      gate_select_pkg::DATA1_SOURCE_OFS:      idx = 4'h4;
      gate_select_pkg::DATA2_SOURCE_OFS:      idx = 4'h5;
      gate_select_pkg::DATA3_SOURCE_OFS:      idx = 4'h6;
      gate_select_pkg::DATA4_SOURCE_OFS:      idx = 4'h7;
      gate_select_pkg::GATE_INVERT_OFS:       idx = gate_select_pkg::IDX_INVERT;
      gate_select_pkg::GATE_STATUS_OFS:       idx = gate_select_pkg::IDX_STATUS;
      default:                                idx = gate_select_pkg::IDX_NONE;
    endcase
    return idx;
  endfunction

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0]  term_sel_q [4];
  logic [4:0]  src_sel_q  [4];
  logic [3:0]  invert_q;
  logic [31:0] src_meta_q;
  logic [31:0] src_sync_q;
  logic [3:0]  data_sel;
  logic [3:0]  gate_raw;
  logic [3:0]  gate_pol;
  logic [3:0]  gate_out_q;
  logic [3:0]  gate_raw_q;

  // Write channel state
  logic        aw_held_q;
  logic [7:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic        w_lane0_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        wr_fire;
  logic [3:0]  wr_idx;
  logic        wr_err;
  logic        wr_apply;
  logic [3:0]  term_we;
  logic [3:0]  src_we;
  logic        invert_we;

  // Read channel state
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [3:0]  rd_idx;
  logic [31:0] rd_word;
  logic        rd_err;

  // ---------------------------------------------------------------
  // Source synchroniser
  // ---------------------------------------------------------------
  // No reset: these flops only carry pin levels onward
  always_ff @(posedge CLOCK) begin
    src_meta_q <= SOURCE_IN;
    src_sync_q <= src_meta_q;
  end

  // ---------------------------------------------------------------
  // Data source selection and gates
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_gate
      assign data_sel[g] = src_sync_q[src_sel_q[g]];
      gate_term_or u_gate (
        .data_in  (data_sel),
        .term_sel (term_sel_q[g]),
        .invert   (invert_q[g]),
        .raw_out  (gate_raw[g]),
        .gate_out (gate_pol[g])
      );
    end
  endgenerate

  // Registered so the cell sees glitch-free gate levels
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      gate_out_q <= 4'h0;
      gate_raw_q <= 4'h0;
    end else begin
      gate_out_q <= gate_pol;
      gate_raw_q <= gate_raw;
    end
  end

  assign GATE_OUT = gate_out_q;

  // ---------------------------------------------------------------
  // Write address and data capture
  // ---------------------------------------------------------------
  // Either channel may arrive first; each is held until both are here
  assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_held_q && !bvalid_q;
  assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx        = reg_index(aw_addr_q);
  assign wr_err        = (wr_idx == gate_select_pkg::IDX_NONE) ||
                         (wr_idx == gate_select_pkg::IDX_STATUS);
  assign wr_apply      = wr_fire && w_lane0_q;

  always_ff @(posedge CLOCK) begin
    if (RESET || WARM_RESET) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET || WARM_RESET) begin
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_q  <= 1'b1;
      w_data_q  <= S_AXI_WDATA;
      w_lane0_q <= S_AXI_WSTRB[0];
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Write response
  // ---------------------------------------------------------------
  // Status register is read-only; writing it or a hole gives SLVERR
  always_ff @(posedge CLOCK) begin
    if (RESET || WARM_RESET) begin
      bvalid_q <= 1'b0;
      bresp_q  <= gate_select_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      if (wr_err) begin
        bresp_q <= gate_select_pkg::RESP_SLVERR;
      end else begin
        bresp_q <= gate_select_pkg::RESP_OKAY;
      end
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP  = bresp_q;

  // ---------------------------------------------------------------
  // Write strobes
  // ---------------------------------------------------------------
  // Holes and the status register raise no strobe
  always_comb begin
    term_we   = 4'h0;
    src_we    = 4'h0;
    invert_we = 1'b0;
    if (wr_apply) begin
      case (wr_idx)
        4'h0, 4'h1, 4'h2, 4'h3: begin
          term_we[wr_idx[1:0]] = 1'b1;
        end
        4'h4, 4'h5, 4'h6, 4'h7: begin
          src_we[wr_idx[1:0]] = 1'b1;
        end
        gate_select_pkg::IDX_INVERT: begin
          invert_we = 1'b1;
        end
        default: begin
          term_we   = 4'h0;
          src_we    = 4'h0;
          invert_we = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Only RESET (power-on class) clears these; WARM_RESET leaves them
  // alone. Only byte lane 0 carries data, so a write with lane 0
  // masked answers OKAY but changes nothing.
  always_ff @(posedge CLOCK) begin
    for (int k = 0; k < 4; k++) begin
      if (RESET) begin
        term_sel_q[k] <= gate_select_pkg::TERM_SELECT_RESET;
      end else if (term_we[k]) begin
        term_sel_q[k] <= w_data_q[7:0];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    for (int k = 0; k < 4; k++) begin
      if (RESET) begin
        src_sel_q[k] <= gate_select_pkg::SOURCE_SEL_RESET;
      end else if (src_we[k]) begin
        src_sel_q[k] <= w_data_q[4:0];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      invert_q <= gate_select_pkg::INVERT_RESET;
    end else if (invert_we) begin
      invert_q <= w_data_q[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  assign rd_idx        = reg_index(S_AXI_ARADDR);
  assign rd_err        = rd_idx == gate_select_pkg::IDX_NONE;
  // Read data is captured with RVALID so it stands until RREADY
  assign S_AXI_ARREADY = !rvalid_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_idx)
      4'h0, 4'h1, 4'h2, 4'h3: rd_word[7:0] = term_sel_q[rd_idx[1:0]];
      4'h4, 4'h5, 4'h6, 4'h7: rd_word[4:0] = src_sel_q[rd_idx[1:0]];
      gate_select_pkg::IDX_INVERT: rd_word[3:0] = invert_q;
      gate_select_pkg::IDX_STATUS: begin
        rd_word[gate_select_pkg::STATUS_RAW_LSB +: 4] = gate_raw_q;
        rd_word[gate_select_pkg::STATUS_OUT_LSB +: 4] = gate_out_q;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET || WARM_RESET) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= gate_select_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      if (rd_err) begin
        rresp_q <= gate_select_pkg::RESP_SLVERR;
      end else begin
        rresp_q <= gate_select_pkg::RESP_OKAY;
      end
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA  = rdata_q;
  assign S_AXI_RRESP  = rresp_q;

endmodule

//--- bench/gate_select_chk.sv
// Checker for bus timing and output clearing of the gate term select stage.
// Assumes it is bound onto gate_select_top and sees only its ports.
`timescale 1ns/1ns
module gate_select_chk (
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic        WARM_RESET,
  input wire logic [3:0]  GATE_OUT,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  // Warm reset also clears the bus side, so it masks every check
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET || WARM_RESET);

  // Both channels are parked one cycle before the write commits
  a_wr_answer: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write answer late");
  a_rd_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read answer late");
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_wr_refuse: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write taken while busy");
  a_rd_refuse: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while busy");
  a_unmapped_rd: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR >= 8'h28
    |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0) else $error("unmapped read answered");
  a_gate_clear: assert property (
    $fell(RESET) |-> GATE_OUT == 4'h0) else $error("gate outputs not cleared");
endmodule

bind gate_select_top gate_select_chk u_chk (.*);

//--- bench/gate_select_top_tb_top.sv
// Self-checking bench for the gate term select stage with its register bus.
// Assumes gate_select_top with a 250 MHz clock; every input is driven here.
`timescale 1ns/1ns
module gate_select_top_tb_top;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        wrst  = 1'b0;
  logic        slow  = 1'b0;
  logic [31:0] src   = 32'h0;
  logic [7:0]  awa   = 8'h00;
  logic [7:0]  ara   = 8'h00;
  logic [31:0] wdt   = 32'h0;
  logic [3:0]  wst   = 4'hF;
  logic        awv   = 1'b0;
  logic        wv    = 1'b0;
  logic        br    = 1'b0;
  logic        arv   = 1'b0;
  logic        rr    = 1'b0;
  logic        awr, wrd, bv, arr, rv;
  logic [1:0]  brs, rrs;
  logic [3:0]  gout;
  logic [31:0] rdt;
  int          errors = 0;
  int          checks = 0;

  always #2 clock = ~clock;

  gate_select_top u_dut (
    .CLOCK(clock), .RESET(rst), .WARM_RESET(wrst), .SOURCE_IN(src), .GATE_OUT(gout),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdt),
    .S_AXI_WSTRB(wst), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(brs),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Ready is raised late when slow is set, so the held response is exercised
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awa <= a;
    wdt <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    // No cycle count is assumed; the loop ends once bv and br are both high, else the watchdog ends it
    forever begin
      @(posedge clock);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv && br) break;
      br <= slow ? bv : !bv;
    end
    r = brs;
    br <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    forever begin
      @(posedge clock);
      if (arr) arv <= 1'b0;
      if (rv && rr) break;
      rr <= slow ? rv : !rv;
    end
    d = rdt;
    r = rrs;
    rr <= 1'b0;
  endtask

  function automatic logic gate_exp(input logic [7:0] s, input logic [3:0] d);
    return |(s & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
  endfunction

  task automatic test_regs;
    logic [31:0] d;
    logic [1:0]  r;
    for (int g = 0; g < 4; g++) begin
      bus_rd(8'(4 * g), d, r);
      chk("term reset", d, 32'(gate_select_pkg::TERM_SELECT_RESET));
      chk("term reset resp", 32'(r), 32'(gate_select_pkg::RESP_OKAY));
    end
    bus_rd(8'h28, d, r);
    chk("unmapped read", {r, d[29:0]}, 32'h8000_0000);
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      for (int g = 0; g < 4; g++) bus_wr(8'(4 * g), {24'hFFFFFF, 8'hA5 ^ {8{k[0]}} ^ 8'(g)}, r);
      for (int g = 0; g < 4; g++) begin
        bus_rd(8'(4 * g), d, r);
        chk("term rw", d, {24'h0, 8'hA5 ^ {8{k[0]}} ^ 8'(g)});
      end
    end
    slow = 1'b0;
    wst <= 4'h0;
    bus_wr(8'h00, 32'h0, r);
    chk("masked write", 32'(r), 32'(gate_select_pkg::RESP_OKAY));
    wst <= 4'hF;
    bus_wr(8'h28, 32'h0, r);
    chk("unmapped write", 32'(r), 32'h2);
    bus_wr(8'h24, 32'h0, r);
    chk("status write", 32'(r), 32'h2);
    wrst <= 1'b1;
    repeat (2) @(posedge clock);
    wrst <= 1'b0;
    for (int g = 0; g < 4; g++) begin
      bus_rd(8'(4 * g), d, r);
      chk("term kept", d, {24'h0, 8'h5A ^ 8'(g)});
    end
  endtask

  task automatic test_terms;
    logic [7:0] sels [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                              8'h00, 8'hA6};
    logic [3:0]  v;
    logic [31:0] d;
    logic [1:0]  r;
    bus_wr(8'h10, 32'hFFFF_FFFF, r);
    bus_wr(8'h14, 32'h10, r);
    bus_wr(8'h18, 32'h5, r);
    bus_wr(8'h1C, 32'h0, r);
    bus_wr(8'h20, 32'h0, r);
    bus_rd(8'h10, d, r);
    chk("source rd", d, 32'h1F);
    for (int i = 0; i < 10; i++) begin
      for (int g = 0; g < 4; g++) bus_wr(8'(4 * g), {24'h0, sels[(i + g) % 10]}, r);
      for (int k = 0; k < 16; k++) begin
        v = 4'(k);
        src <= {v[0], 14'h2A5C, v[1], 10'h1CB, v[2], 4'h9, v[3]};
        repeat (4) @(posedge clock);
        chk("gate1", 32'(gout[0]), 32'(gate_exp(sels[i % 10], v)));
        chk("gate2", 32'(gout[1]), 32'(gate_exp(sels[(i + 1) % 10], v)));
        chk("gate3", 32'(gout[2]), 32'(gate_exp(sels[(i + 2) % 10], v)));
        chk("gate4", 32'(gout[3]), 32'(gate_exp(sels[(i + 3) % 10], v)));
      end
    end
  endtask

  task automatic test_invert;
    logic [31:0] d;
    logic [1:0]  r;
    bus_wr(8'h00, 32'h03, r);
    for (int g = 1; g < 4; g++) bus_wr(8'(4 * g), 32'h0, r);
    for (int p = 0; p < 2; p++) begin
      bus_wr(8'h20, p ? 32'hA : 32'h5, r);
      repeat (2) @(posedge clock);
      chk("invert", 32'(gout), p ? 32'hB : 32'h4);
      bus_rd(8'h20, d, r);
      chk("invert rd", d, p ? 32'hA : 32'h5);
      bus_rd(8'h24, d, r);
      chk("status rd", d, p ? 32'hB1 : 32'h41);
    end
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    test_regs;
    test_terms;
    test_invert;
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge clock);
    $display("[ERR] watchdog expected finish seen timeout");
    errors++;
    finish_test;
  end
endmodule
